// file: rtl/axio_consts.svh
// axis i/o block: register offsets, field positions, reset values, timing
// assumes byte addresses decoded on haddr[7:0]
`ifndef AXIO_CONSTS_SVH
`define AXIO_CONSTS_SVH
// ==========================================
// register offsets
`define AXIO_OFS_CTRL       8'h00
`define AXIO_OFS_OUT        8'h04
`define AXIO_OFS_X_IN       8'h08
`define AXIO_OFS_Y_IN       8'h0C
`define AXIO_OFS_X_ERR      8'h10
`define AXIO_OFS_Y_ERR      8'h14
`define AXIO_OFS_ISTAT      8'h18
`define AXIO_OFS_IMASK      8'h1C
// ==========================================
// field positions
`define AXIO_CTRL_MODE_LSB  0
`define AXIO_CTRL_DCC_LSB   2
`define AXIO_CTRL_EXT_LSB   4
`define AXIO_GIN_LSB        8
`define AXIO_EMG_BIT        5
`define AXIO_IRQ_EMG        0
`define AXIO_IRQ_START_LSB  1
// ==========================================
// reset values
`define AXIO_CTRL_RST       8'h00
`define AXIO_OUT_RST        16'h0000
`define AXIO_IRQ_RST        3'h0
// ==========================================
// timing: synchroniser depth in clock cycles
`define AXIO_SYNC_CYCLES    2
`endif

// file: rtl/axio_pkg.sv
// axis i/o block: shared types
// assumes axio_consts.svh holds the numbers
package axio_pkg;
  typedef enum logic [1:0] {
    AXIO_EXT_OFF   = 2'b00,
    AXIO_EXT_FIXED = 2'b01,
    AXIO_EXT_CONT  = 2'b10
  } axio_ext_mode_t;
endpackage : axio_pkg

// file: rtl/axio_top.sv
// axis i/o block: shared output pins, input mirror, external start, e-stop
// assumes one 20 MHz clock, ahb-lite single word transfers, one slave
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`include "axio_consts.svh"

// How it works
// - status mode: minus-compare pin high below minus limit, low above.
// - status mode: plus-compare pin high above plus limit, low below.
// - status mode: pin 1 high while s-curve jerk magnitude decreasing.
// - status mode: pin 0 high while s-curve jerk magnitude increasing, unless deviation clear is enabled.
// - deviation clear enabled: clear pulse appears on shared pin 0.
// - outside status mode every shared pin is a plain general output, except pin 0 while deviation clear is enabled.
// - six general inputs shown in bits 13..8 of each axis input register.
// - general inputs read as their level, low 0, high 1, not inverted.
// - fixed external mode: falling start input launches one fixed drive.
// - continuous external mode: drive runs while start input stays low.
// - emergency input low halts pulse output on both axes at once.
// - emergency sets the emergency error bit of both axis error registers.
// - emergency input is always active low, no polarity setting.
// - x outputs follow output register bits 7..0, y bits 15..8.
// - all general outputs low after reset.
module axio_top
  import axio_pkg::*;
#(
  parameter int PW = 32
) (
  // clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   RESET_N,
  // ahb-lite slave
  input  wire logic                   HSEL,
  input  wire logic [31:0]            HADDR,
  input  wire logic [1:0]             HTRANS,
  input  wire logic                   HWRITE,
  input  wire logic [2:0]             HSIZE,
  input  wire logic [31:0]            HWDATA,
  input  wire logic                   HREADY,
  output logic      [31:0]            HRDATA,
  output logic                        HREADYOUT,
  output logic                        HRESP,
  // interrupt
  output logic                        IRQ,
  // drive state from the axis cores, index 0 is x, 1 is y
  input  wire logic [1:0][PW-1:0]     AXIS_POS,
  input  wire logic [1:0][PW-1:0]     CMP_MINUS,
  input  wire logic [1:0][PW-1:0]     CMP_PLUS,
  input  wire logic [1:0]             JERK_DEC,
  input  wire logic [1:0]             JERK_INC,
  input  wire logic [1:0][3:0]        DRV_STATUS,
  input  wire logic [1:0]             DEV_CLEAR_REQ,
  // external pins
  input  wire logic [1:0][5:0]        GENERAL_INPUT,
  input  wire logic [1:0]             EXT_START_PLUS,
  input  wire logic [1:0]             EXT_START_MINUS,
  input  wire logic                   EMERGENCY_STOP_N,
  output logic      [1:0][7:0]        GENERAL_OUTPUT,
  // drive requests to the pulse generators
  output logic      [1:0]             START_FIXED_PLUS,
  output logic      [1:0]             START_FIXED_MINUS,
  output logic      [1:0]             CONT_PLUS,
  output logic      [1:0]             CONT_MINUS,
  output logic                        PULSE_HALT
);

  localparam int SW = 17;

  // ==========================================
  // helpers
  function automatic logic w1c(input logic old, input logic set, input logic clr);
    // set beats a clear landing in the same cycle
    w1c = set | (old & ~clr);
  endfunction : w1c

  function automatic logic cmp_flag(input logic [PW-1:0] pos, input logic [PW-1:0] lim,
                                    input logic old, input logic below);
    // equal keeps the last level; only strict sides are defined
    if ($signed(pos) < $signed(lim)) begin
      cmp_flag = below;
    end else if ($signed(pos) > $signed(lim)) begin
      cmp_flag = ~below;
    end else begin
      cmp_flag = old;
    end
  endfunction : cmp_flag

  // ==========================================
  // input synchroniser
  logic [SW-1:0] s1_r, s2_r, s3_r;
  logic [SW-1:0] s1_nxt, s2_nxt, s3_nxt;

  always_comb begin
    s1_nxt = {EMERGENCY_STOP_N, EXT_START_MINUS, EXT_START_PLUS, GENERAL_INPUT};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  logic [1:0][5:0] gin_s;
  logic [1:0]      plus_s, minus_s, plus_p, minus_p;
  logic            emg_act;
  assign gin_s   = s2_r[11:0];
  assign plus_s  = s2_r[13:12];
  assign minus_s = s2_r[15:14];
  assign plus_p  = s3_r[13:12];
  assign minus_p = s3_r[15:14];
  assign emg_act = ~s2_r[16];

  // ==========================================
  // ahb-lite slave
  logic        wr_pend_r, wr_pend_nxt;
  logic [7:0]  wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic        addr_ok;

  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [15:0] gout_r, gout_nxt;
  logic [1:0]  err_r, err_nxt;
  logic [2:0]  istat_r, istat_nxt, imask_r, imask_nxt;
  logic        irq_r, irq_nxt;

  assign addr_ok = HSEL & HTRANS[1] & HREADY;

  always_comb begin
    wr_pend_nxt = addr_ok & HWRITE;
    wr_addr_nxt = addr_ok ? HADDR[7:0] : wr_addr_r;
    hrdata_nxt  = 32'h0000_0000;
    if (addr_ok && !HWRITE) begin
      case (HADDR[7:0])
        `AXIO_OFS_CTRL:  hrdata_nxt[7:0]  = ctrl_r;
        `AXIO_OFS_OUT:   hrdata_nxt[15:0] = gout_r;
        `AXIO_OFS_X_IN:  hrdata_nxt[`AXIO_GIN_LSB +: 6] = gin_s[0];
        `AXIO_OFS_Y_IN:  hrdata_nxt[`AXIO_GIN_LSB +: 6] = gin_s[1];
        `AXIO_OFS_X_ERR: hrdata_nxt[`AXIO_EMG_BIT] = err_r[0];
        `AXIO_OFS_Y_ERR: hrdata_nxt[`AXIO_EMG_BIT] = err_r[1];
        `AXIO_OFS_ISTAT: hrdata_nxt[2:0]  = istat_r;
        `AXIO_OFS_IMASK: hrdata_nxt[2:0]  = imask_r;
        default:         hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  assign HRDATA    = hrdata_r;
  // zero wait states, so ready and okay are tied constants, not flops
  assign HREADYOUT = RESET_N | 1'b1;
  assign HRESP     = 1'b0;

  // ==========================================
  // drive requests and shared pins
  logic [1:0]      fixp_r, fixm_r, contp_r, contm_r, fixp_nxt, fixm_nxt;
  logic [1:0]      contp_nxt, contm_nxt;
  logic            halt_r, halt_nxt;
  logic [1:0]      compare_minus_out_r, compare_plus_out_r, compare_minus_out_nxt, compare_plus_out_nxt;
  logic [1:0][7:0] pin_r, pin_nxt;
  logic [1:0][7:0] stat_vec;
  axio_ext_mode_t  ext_mode [2];

  always_comb begin
    halt_nxt = emg_act;
    for (int a = 0; a < 2; a++) begin
      ext_mode[a] = axio_ext_mode_t'(ctrl_r[`AXIO_CTRL_EXT_LSB + 2*a +: 2]);
      fixp_nxt[a] = (ext_mode[a] == AXIO_EXT_FIXED) & plus_p[a] & ~plus_s[a]
                    & ~emg_act;
      fixm_nxt[a] = (ext_mode[a] == AXIO_EXT_FIXED) & minus_p[a] & ~minus_s[a]
                    & ~emg_act;
      contp_nxt[a] = (ext_mode[a] == AXIO_EXT_CONT) & ~plus_s[a] & ~emg_act;
      contm_nxt[a] = (ext_mode[a] == AXIO_EXT_CONT) & ~minus_s[a] & ~emg_act;
      compare_minus_out_nxt[a] = cmp_flag(AXIS_POS[a], CMP_MINUS[a], compare_minus_out_r[a], 1'b1);
      compare_plus_out_nxt[a] = cmp_flag(AXIS_POS[a], CMP_PLUS[a], compare_plus_out_r[a], 1'b0);
      stat_vec[a] = {DRV_STATUS[a], compare_minus_out_nxt[a], compare_plus_out_nxt[a],
                     JERK_DEC[a], JERK_INC[a]};
      pin_nxt[a] = ctrl_r[`AXIO_CTRL_MODE_LSB + a] ? stat_vec[a]
                                                   : gout_r[8*a +: 8];
      if (ctrl_r[`AXIO_CTRL_DCC_LSB + a]) begin
        pin_nxt[a][0] = DEV_CLEAR_REQ[a];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      fixp_r  <= 2'b00;
      fixm_r  <= 2'b00;
      contp_r <= 2'b00;
      contm_r <= 2'b00;
      halt_r  <= 1'b0;
      compare_minus_out_r  <= 2'b00;
      compare_plus_out_r  <= 2'b00;
      pin_r   <= '0;
    end else begin
      fixp_r  <= fixp_nxt;
      fixm_r  <= fixm_nxt;
      contp_r <= contp_nxt;
      contm_r <= contm_nxt;
      halt_r  <= halt_nxt;
      compare_minus_out_r  <= compare_minus_out_nxt;
      compare_plus_out_r  <= compare_plus_out_nxt;
      pin_r   <= pin_nxt;
    end
  end

  assign START_FIXED_PLUS  = fixp_r;
  assign START_FIXED_MINUS = fixm_r;
  assign CONT_PLUS         = contp_r;
  assign CONT_MINUS        = contm_r;
  assign PULSE_HALT        = halt_r;
  assign GENERAL_OUTPUT    = pin_r;

  // ==========================================
  // registers and interrupt
  logic [31:0] wdat;
  logic        wr_ctrl, wr_out, wr_xerr, wr_yerr, wr_istat, wr_imask;
  logic [2:0]  ev;

  always_comb begin
    wdat     = HWDATA;
    wr_ctrl  = wr_pend_r & (wr_addr_r == `AXIO_OFS_CTRL);
    wr_out   = wr_pend_r & (wr_addr_r == `AXIO_OFS_OUT);
    wr_xerr  = wr_pend_r & (wr_addr_r == `AXIO_OFS_X_ERR);
    wr_yerr  = wr_pend_r & (wr_addr_r == `AXIO_OFS_Y_ERR);
    wr_istat = wr_pend_r & (wr_addr_r == `AXIO_OFS_ISTAT);
    wr_imask = wr_pend_r & (wr_addr_r == `AXIO_OFS_IMASK);
    ctrl_nxt  = wr_ctrl ? wdat[7:0] : ctrl_r;
    gout_nxt  = wr_out ? wdat[15:0] : gout_r;
    imask_nxt = wr_imask ? wdat[2:0] : imask_r;
    err_nxt[0] = w1c(err_r[0], emg_act, wr_xerr & wdat[`AXIO_EMG_BIT]);
    err_nxt[1] = w1c(err_r[1], emg_act, wr_yerr & wdat[`AXIO_EMG_BIT]);
    ev[`AXIO_IRQ_EMG] = emg_act;
    ev[`AXIO_IRQ_START_LSB +: 2] = fixp_nxt | fixm_nxt;
    for (int i = 0; i < 3; i++) begin
      istat_nxt[i] = w1c(istat_r[i], ev[i], wr_istat & wdat[i]);
    end
    irq_nxt = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ctrl_r  <= `AXIO_CTRL_RST;
      gout_r  <= `AXIO_OUT_RST;
      err_r   <= 2'b00;
      istat_r <= `AXIO_IRQ_RST;
      imask_r <= `AXIO_IRQ_RST;
      irq_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      gout_r  <= gout_nxt;
      err_r   <= err_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign IRQ = irq_r;

  // ==========================================
  // checks
  logic [1:0] settle_r;
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      settle_r <= 2'd0;
    end else if (settle_r != 2'd3) begin
      settle_r <= settle_r + 2'd1;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  minus_cmp_a: assert property (
    ctrl_r[0] && ($signed(AXIS_POS[0]) < $signed(CMP_MINUS[0])) |=> GENERAL_OUTPUT[0][3])
    else $error("minus compare pin not high below limit");
  plus_cmp_a: assert property (
    ctrl_r[1] && ($signed(AXIS_POS[1]) < $signed(CMP_PLUS[1])) |=> !GENERAL_OUTPUT[1][2])
    else $error("plus compare pin not low below limit");
  jerk_dec_a: assert property (
    ctrl_r[0] |=> GENERAL_OUTPUT[0][1] == $past(JERK_DEC[0]))
    else $error("jerk decreasing pin wrong");
  jerk_inc_a: assert property (
    ctrl_r[1] && !ctrl_r[3] |=> GENERAL_OUTPUT[1][0] == $past(JERK_INC[1]))
    else $error("jerk increasing pin wrong");
  dcc_pin_a: assert property (
    ctrl_r[2] |=> GENERAL_OUTPUT[0][0] == $past(DEV_CLEAR_REQ[0]))
    else $error("deviation clear not on pin 0");
  gen_out_a: assert property (
    !ctrl_r[1] && !ctrl_r[3] |=> GENERAL_OUTPUT[1] == $past(gout_r[15:8]))
    else $error("y pins do not follow output register");
  mode_all_a: assert property (
    !ctrl_r[0] |=> GENERAL_OUTPUT[0][7:1] == $past(gout_r[7:1]))
    else $error("x pins not switched together");
  gin_mirror_a: assert property (
    settle_r == 2'd3 |-> gin_s == $past(GENERAL_INPUT, 2))
    else $error("general input not two flops late");
  emg_halt_a: assert property (
    !EMERGENCY_STOP_N |-> ##3 (PULSE_HALT && CONT_PLUS == 2'b00 && CONT_MINUS == 2'b00))
    else $error("emergency did not halt");
  emg_err_a: assert property (
    PULSE_HALT |-> err_r == 2'b11 && istat_r[0])
    else $error("emergency error bits not set");
  fixed_start_a: assert property (
    START_FIXED_PLUS[0] |-> $past(plus_p[0]) && !$past(plus_s[0]) && $past(ctrl_r[5:4]) == 2'b01)
    else $error("fixed start without falling edge");
  cont_run_a: assert property (
    ctrl_r[7:6] == 2'b10 && !minus_s[1] && !emg_act |=> CONT_MINUS[1])
    else $error("continuous drive not running");
  rst_low_a: assert property (disable iff (1'b0)
    !RESET_N |=> GENERAL_OUTPUT == '0)
    else $error("outputs not low after reset");

endmodule : axio_top

// file: test/axio_pin_model.sv
// axis i/o bench: outside party driving the switch and e-stop pins
// assumes the bench calls its tasks; pins idle high as if pulled up
`timescale 1ns/100ps
module axio_pin_model (
  // clock
  input  wire logic            clk,
  // pins toward the block
  output logic      [1:0][5:0] gen_in,
  output logic      [1:0]      start_plus,
  output logic      [1:0]      start_minus,
  output logic                 estop_n
);
  int low_cnt;
  initial begin
    gen_in      = '1;
    start_plus  = '1;
    start_minus = '1;
    estop_n     = 1'b1;
    low_cnt     = 0;
  end
  always @(posedge clk) begin
    low_cnt <= estop_n ? 0 : low_cnt + 1;
  end
  task automatic drive(input logic [1:0][5:0] g, input logic [1:0] p, input logic [1:0] m);
    @(posedge clk);
    gen_in      <= g;
    start_plus  <= p;
    start_minus <= m;
  endtask : drive
  task automatic estop(input logic on);
    int i;
    i = 0;
    @(posedge clk);
    if (on) begin
      estop_n <= 1'b0;
    end else begin
      // low time kept above two clocks so the block can see it
      while (low_cnt < 3 && i < 8) begin
        i++;
        @(posedge clk);
      end
      estop_n <= 1'b1;
    end
  endtask : estop
endmodule : axio_pin_model

// file: test/tb_axio_top.sv
// axis i/o bench: register tests over ahb-lite with expected values
// assumes zero wait state slave, one clock at 20 MHz
`timescale 1ns/100ps
`include "axio_consts.svh"
module tb_axio_top;
  import axio_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0, jdec = '0, jinc = '0, dclr = '0;
  logic hready, hresp, irq, halt;
  logic [1:0][31:0] pos = '0, cmin = '0, cplus = '0;
  logic [1:0][3:0] drv = '0;
  logic [1:0][5:0] gin;
  logic [1:0] sp, sm, sfp, sfm, cp, cm;
  logic estop_n;
  logic [1:0][7:0] gout;
  int n_fail = 0, n_compared = 0;
  logic [31:0] k;
  always #25 clk = ~clk;
  axio_pin_model u_axio_pin_model (.clk(clk), .gen_in(gin), .start_plus(sp),
    .start_minus(sm), .estop_n(estop_n));
  axio_top u_axio_top (.CORE_CLK(clk), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq), .AXIS_POS(pos),
    .CMP_MINUS(cmin), .CMP_PLUS(cplus), .JERK_DEC(jdec), .JERK_INC(jinc),
    .DRV_STATUS(drv), .DEV_CLEAR_REQ(dclr), .GENERAL_INPUT(gin),
    .EXT_START_PLUS(sp), .EXT_START_MINUS(sm), .EMERGENCY_STOP_N(estop_n),
    .GENERAL_OUTPUT(gout), .START_FIXED_PLUS(sfp), .START_FIXED_MINUS(sfm),
    .CONT_PLUS(cp), .CONT_MINUS(cm), .PULSE_HALT(halt));
  // ==========================================
  // shared tasks
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic wait_ready;
    int i;
    i = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      if (++i > 16) begin
        n_fail++;
        wrap_up();
      end
      @(posedge clk);
    end
  endtask : wait_ready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0000_00, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdchk
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks
  task automatic pins(input logic [15:0] e);
    ticks(3);
    chk("pins", {16'h0000, e}, {16'h0000, gout});
  endtask : pins
  // ==========================================
  // tests
  initial begin
    ticks(10);
    rst_n <= 1'b1;
    @(posedge clk);
    pins(16'h0000);
    rdchk("ctrl", `AXIO_OFS_CTRL, 32'h0000_0000);
    rdchk("out", `AXIO_OFS_OUT, 32'h0000_0000);
    bus(`AXIO_OFS_OUT, 1'b1, 32'h0000_A55A);
    pins(16'hA55A);
    rdchk("out", `AXIO_OFS_OUT, 32'h0000_A55A);
    bus(8'h40, 1'b1, 32'h0000_FFFF);
    rdchk("unmapped", 8'h40, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
    $display("test outputs done");
    u_axio_pin_model.drive({6'h15, 6'h2A}, 2'b11, 2'b11);
    bus(`AXIO_OFS_X_IN, 1'b1, 32'h0000_0000);
    ticks(4);
    rdchk("x_in", `AXIO_OFS_X_IN, 32'h0000_2A00);
    rdchk("y_in", `AXIO_OFS_Y_IN, 32'h0000_1500);
    $display("test inputs done");
    pos[0] <= 32'd10;
    cmin[0] <= 32'd20;
    cplus[0] <= 32'd5;
    jdec[0] <= 1'b1;
    drv[0] <= 4'b1010;
    bus(`AXIO_OFS_CTRL, 1'b1, 32'h0000_0001);
    pins(16'hA5AE);
    pos[0] <= 32'd30;
    cplus[0] <= 32'd40;
    jdec[0] <= 1'b0;
    jinc[0] <= 1'b1;
    drv[0] <= 4'b0000;
    pins(16'hA501);
    bus(`AXIO_OFS_CTRL, 1'b1, 32'h0000_0004);
    dclr[0] <= 1'b1;
    pins(16'hA55B);
    dclr[0] <= 1'b0;
    pos[1] <= 32'd5;
    cmin[1] <= 32'd9;
    cplus[1] <= 32'd7;
    jinc[1] <= 1'b1;
    drv[1] <= 4'b0101;
    bus(`AXIO_OFS_CTRL, 1'b1, 32'h0000_0002);
    pins(16'h595A);
    bus(`AXIO_OFS_CTRL, 1'b1, 32'h0000_000A);
    pins(16'h585A);
    $display("test shared pins done");
    bus(`AXIO_OFS_CTRL, 1'b1, 32'h0000_0010);
    u_axio_pin_model.drive({6'h15, 6'h2A}, 2'b10, 2'b11);
    k = 32'h0000_0000;
    repeat (10) begin
      @(posedge clk);
      #1 k = k + {31'h0, sfp[0]};
    end
    chk("fixed pulses", 32'd1, k);
    chk("fixed minus", 32'h0000_0000, {30'h0, sfm});
    rdchk("istat", `AXIO_OFS_ISTAT, 32'h0000_0002);
    bus(`AXIO_OFS_ISTAT, 1'b1, 32'h0000_0002);
    rdchk("istat clr", `AXIO_OFS_ISTAT, 32'h0000_0000);
    bus(`AXIO_OFS_CTRL, 1'b1, 32'h0000_0080);
    u_axio_pin_model.drive({6'h15, 6'h2A}, 2'b11, 2'b01);
    ticks(6);
    chk("cont", 32'h0000_0002, {28'h0, cp, cm});
    u_axio_pin_model.drive({6'h15, 6'h2A}, 2'b11, 2'b11);
    ticks(6);
    chk("cont off", 32'h0000_0000, {28'h0, cp, cm});
    $display("test external start done");
    bus(`AXIO_OFS_IMASK, 1'b1, 32'h0000_0001);
    fork
      u_axio_pin_model.estop(1'b1);
    join_none
    ticks(5);
    chk("halt", 32'h0000_0001, {31'h0, halt});
    chk("irq", 32'h0000_0001, {31'h0, irq});
    u_axio_pin_model.estop(1'b0);
    ticks(5);
    chk("halt off", 32'h0000_0000, {31'h0, halt});
    rdchk("x_err", `AXIO_OFS_X_ERR, 32'h0000_0020);
    rdchk("y_err", `AXIO_OFS_Y_ERR, 32'h0000_0020);
    bus(`AXIO_OFS_X_ERR, 1'b1, 32'h0000_0020);
    rdchk("x_err clr", `AXIO_OFS_X_ERR, 32'h0000_0000);
    bus(`AXIO_OFS_ISTAT, 1'b1, 32'h0000_0001);
    ticks(2);
    chk("irq off", 32'h0000_0000, {31'h0, irq});
    $display("test emergency done");
    wrap_up();
  end
endmodule : tb_axio_top
